/* File: design/rx_master_clock_select.sv */
// Purpose: Input selector, master-clock source switch, ratio meter and serial clock pins
// Assumes: Clock-type pins are slow enough to be sampled at 25 MHz; lock comes from the analog loop
// Notes:   Clock outputs are derived from sampled clocks and re-timed, so switching is glitch free
// Function
// - Low chip reset clears control, stream, clock-switch, divider, ratio and frame state and signals low-power.
// - Eight biphase inputs feed an 8:2 selector: receiver and pass-through.
// - Selector fields live in the control register at 04h.
// - System-clock mode and loop unlock put external clock on master clock out.
// - Measure recovered clock against external clock reference, report at 18h.
// - Master clock is 256x by default, 128x when half-rate bit at 01h set.
// - Receiver-disable bit at 04h tri-states the master clock output.
// - Bit clock pin is driven by device in master mode, else by the partner.
// - Word clock frames serial output data at the sample rate.
`timescale 1ns/1ps
module rx_master_clock_select
   import mclk_sel_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  chip_reset_n_i,
   input  wire logic [NUM_INPUTS-1:0] biphase_in_pos_i,
   input  wire logic                  ext_system_clock_i,
   input  wire logic                  loop_clock_i,
   input  wire logic                  loop_lock_i,
   input  wire logic [ADDR_W-1:0]     addr_i,
   input  wire logic [DATA_W-1:0]     wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [DATA_W-1:0]     rdata_o,
   output logic                       low_power_o,
   output logic                       receiver_stream_o,
   output logic                       passthrough_stream_o,
   output logic                       recovered_master_clock_o,
   output logic                       recovered_master_clock_oe_o,
   input  wire logic                  audio_bit_clock_i,
   output logic                       audio_bit_clock_o,
   output logic                       audio_bit_clock_oe_o,
   input  wire logic                  audio_word_clock_i,
   output logic                       audio_word_clock_o,
   output logic                       audio_word_clock_oe_o
);
   logic [NUM_INPUTS-1:0]  pos_s;
   logic                   nrst_s;
   logic                   ext_s;
   logic                   loop_s;
   logic                   lock_s;
   logic                   bclk_s;
   logic                   lrck_s;
   logic                   chip_in_reset;
   logic [DATA_W-1:0]      ctrl1_reg;
   logic [DATA_W-1:0]      ctrl4_reg;
   logic [DATA_W-1:0]      ratio_reg;
   logic [DATA_W-1:0]      rdata_next;
   logic                   ext_d_reg;
   logic                   loop_d_reg;
   logic                   ext_rise;
   logic                   loop_rise;
   logic                   half_reg;
   logic                   src_clk;
   logic                   want_ext;
   logic                   use_ext_reg;
   logic [RATIO_WIN_W-1:0] ref_cnt_reg;
   logic [DATA_W-1:0]      meas_cnt_reg;
   logic [FRAME_CNT_W-1:0] frame_cnt_reg;
   logic [SEL_W-1:0]       rx_sel;
   logic [SEL_W-1:0]       pass_sel;
   logic                   port_master;

   sync_stage #(.WIDTH(NUM_INPUTS + 6)) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({biphase_in_pos_i, chip_reset_n_i, ext_system_clock_i, loop_clock_i,
               loop_lock_i, audio_bit_clock_i, audio_word_clock_i}),
      .q_o   ({pos_s, nrst_s, ext_s, loop_s, lock_s, bclk_s, lrck_s})
   );

   assign chip_in_reset = !nrst_s;
   assign low_power_o   = chip_in_reset;
   assign rx_sel        = ctrl4_reg[C4_RX_LSB +: SEL_W];
   assign pass_sel      = ctrl4_reg[C4_PASS_LSB +: SEL_W];
   assign port_master   = ctrl1_reg[C1_PORT_MSTR];

   // Control registers; a held chip reset keeps them at default
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl1_reg <= CTRL1_RESET;
         ctrl4_reg <= CTRL4_RESET;
      end
      else if (chip_in_reset)
      begin
         ctrl1_reg <= CTRL1_RESET;
         ctrl4_reg <= CTRL4_RESET;
      end
      else if (wr_i)
      begin
         if (addr_i == ADDR_CTRL1)
            ctrl1_reg <= wdata_i & CTRL1_MASK;
         if (addr_i == ADDR_CTRL4)
            ctrl4_reg <= wdata_i & CTRL4_MASK;
      end
   end

   assign rdata_next = (addr_i == ADDR_CTRL1) ? ctrl1_reg :
                       (addr_i == ADDR_CTRL4) ? ctrl4_reg :
                       (addr_i == ADDR_RATIO) ? ratio_reg : '0;
   // Read data stands for one cycle only
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_o <= '0;
      else if (rd_i)
         rdata_o <= rdata_next;
      else
         rdata_o <= '0;
   end

   // Input selector
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         receiver_stream_o    <= 1'b0;
         passthrough_stream_o <= 1'b0;
      end
      else if (chip_in_reset)
      begin
         receiver_stream_o    <= 1'b0;
         passthrough_stream_o <= 1'b0;
      end
      else
      begin
         receiver_stream_o    <= pos_s[rx_sel];
         passthrough_stream_o <= pos_s[pass_sel];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ext_d_reg  <= 1'b0;
         loop_d_reg <= 1'b0;
      end
      else
      begin
         ext_d_reg  <= ext_s;
         loop_d_reg <= loop_s;
      end
   end

   assign ext_rise  = ext_s && !ext_d_reg;
   assign loop_rise = loop_s && !loop_d_reg;

   // Half-rate divider runs on recovered clock rising edges
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         half_reg <= 1'b0;
      else if (chip_in_reset)
         half_reg <= 1'b0;
      else if (loop_rise)
         half_reg <= !half_reg;
   end

   assign src_clk  = ctrl1_reg[C1_HALF_RATE] ? half_reg : loop_s;
   assign want_ext = ctrl1_reg[C1_SYSCLK_EN] && !lock_s;

   // Source only changes while both candidates are low, so no runt pulse appears
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         use_ext_reg <= 1'b0;
      else if (chip_in_reset)
         use_ext_reg <= 1'b0;
      else if ((want_ext != use_ext_reg) && !ext_s && !src_clk)
         use_ext_reg <= want_ext;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         recovered_master_clock_o <= 1'b0;
      else if (chip_in_reset)
         recovered_master_clock_o <= 1'b0;
      else
         recovered_master_clock_o <= use_ext_reg ? ext_s : src_clk;
   end

   assign recovered_master_clock_oe_o = !ctrl4_reg[C4_RX_DIS] && !chip_in_reset;

   // Ratio meter: the external clock sets the window, recovered edges are counted in it
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ref_cnt_reg  <= '0;
         meas_cnt_reg <= '0;
         ratio_reg    <= RATIO_RESET;
      end
      else if (chip_in_reset)
      begin
         ref_cnt_reg  <= '0;
         meas_cnt_reg <= '0;
         ratio_reg    <= RATIO_RESET;
      end
      else
      begin
         if (ext_rise)
            ref_cnt_reg <= ref_cnt_reg + 1'b1;
         if (ext_rise && (ref_cnt_reg == '1))
         begin
            ratio_reg    <= meas_cnt_reg;
            meas_cnt_reg <= {7'h00, loop_rise};
         end
         else if (loop_rise && (meas_cnt_reg != RATIO_MAX))
            meas_cnt_reg <= meas_cnt_reg + 1'b1;
      end
   end

   // Serial port clocks derived from recovered clock when the port is master
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         frame_cnt_reg <= '0;
      else if (chip_in_reset)
         frame_cnt_reg <= '0;
      else if (loop_rise)
         frame_cnt_reg <= frame_cnt_reg + 1'b1;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         audio_bit_clock_o  <= 1'b0;
         audio_word_clock_o <= 1'b0;
      end
      else
      begin
         audio_bit_clock_o  <= frame_cnt_reg[BCLK_BIT];
         audio_word_clock_o <= frame_cnt_reg[LRCK_BIT];
      end
   end

   // In slave mode the partner owns both pins; bclk_s and lrck_s carry its timing
   assign audio_bit_clock_oe_o  = port_master && !chip_in_reset;
   assign audio_word_clock_oe_o = port_master && !chip_in_reset;
   sequence s_both_low;
      !ext_s && !src_clk;
   endsequence
   sequence s_ratio_close;
      ext_rise && (ref_cnt_reg == '1);
   endsequence
   property p_switch_quiet;
      @(posedge clk_i) disable iff (rst_i)
      ($changed(use_ext_reg) && !$past(chip_in_reset)) |-> $past(!ext_s && !src_clk);
   endproperty
   a_reset_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      chip_in_reset |=> (ctrl1_reg == CTRL1_RESET) && (ratio_reg == RATIO_RESET) && !use_ext_reg)
      else $error("chip reset did not clear state");
   a_rx_select: assert property (@(posedge clk_i) disable iff (rst_i)
      !chip_in_reset ##1 !$past(chip_in_reset) |-> receiver_stream_o == $past(pos_s[rx_sel]))
      else $error("receiver stream not from selected input");
   a_ctrl4_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_i && addr_i == ADDR_CTRL4 && !chip_in_reset) |=> rx_sel == $past(wdata_i[C4_RX_LSB +: SEL_W]))
      else $error("selector field not written at 04h");
   a_sysclk_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (use_ext_reg && want_ext && !chip_in_reset) |=> recovered_master_clock_o == $past(ext_s))
      else $error("external clock not passed in system-clock mode");
   a_ratio_report: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_ratio_close and !chip_in_reset) |=> ratio_reg == $past(meas_cnt_reg))
      else $error("ratio register not updated at window end");
   a_half_rate: assert property (@(posedge clk_i) disable iff (rst_i)
      (loop_rise && !chip_in_reset) |=> half_reg != $past(half_reg)) else $error("half-rate divider missed an edge");
   a_tristate_out: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl4_reg[C4_RX_DIS] |-> !recovered_master_clock_oe_o) else $error("master clock driven while receiver off");
   a_port_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      !port_master |-> !audio_bit_clock_oe_o && !audio_word_clock_oe_o) else $error("serial clocks driven as slave");
   a_word_frame: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(audio_word_clock_o) |-> $past(frame_cnt_reg[LRCK_BIT - 1:0] == '0))
      else $error("word clock edge off frame boundary");
   a_switch_quiet: assert property (p_switch_quiet) else $error("source switched while a clock was high");
   a_switch_low: assert property (@(posedge clk_i) disable iff (rst_i)
      ($changed(use_ext_reg) && !$past(chip_in_reset)) |-> s_both_low or !recovered_master_clock_o)
      else $error("runt pulse around source switch");
   a_read_once: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_i && addr_i == ADDR_RATIO) ##1 !rd_i |-> ##1 rdata_o == '0)
      else $error("read data stood longer than one cycle");
endmodule

/* File: design/mclk_sel_pkg.sv */
// Purpose: Shared constants for the receiver master-clock and input-select block
// Assumes: 8-bit register port, 25 MHz system clock
// Notes:   Bit positions inside the control registers are local choices
package mclk_sel_pkg;
   localparam int unsigned ADDR_W       = 8;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned NUM_INPUTS   = 8;
   localparam int unsigned SEL_W        = 3;

   localparam logic [7:0] ADDR_CTRL1    = 8'h01;
   localparam logic [7:0] ADDR_CTRL4    = 8'h04;
   localparam logic [7:0] ADDR_RATIO    = 8'h18;

   // Control 1 fields
   localparam int unsigned C1_HALF_RATE = 0;
   localparam int unsigned C1_SYSCLK_EN = 1;
   localparam int unsigned C1_PORT_MSTR = 2;
   localparam logic [7:0] CTRL1_RESET  = 8'h00;

   // Control 4 fields and the write masks of both control registers
   localparam int unsigned C4_PASS_LSB  = 0;
   localparam int unsigned C4_RX_LSB    = 3;
   localparam int unsigned C4_RX_DIS    = 7;
   localparam logic [7:0] CTRL4_RESET  = 8'h00;
   localparam logic [7:0] CTRL1_MASK   = 8'h07;
   localparam logic [7:0] CTRL4_MASK   = 8'hBF;

   // Ratio measurement: window of reference edges on the external clock
   localparam int unsigned RATIO_WIN_W  = 6;
   localparam logic [7:0] RATIO_RESET  = 8'h00;
   localparam logic [7:0] RATIO_MAX    = 8'hFF;

   // Serial port master timing, counted in recovered clock edges
   localparam int unsigned FRAME_CNT_W  = 8;
   localparam int unsigned BCLK_BIT     = 1;
   localparam int unsigned LRCK_BIT     = 7;
endpackage

/* File: design/sync_stage.sv */
// Purpose: Two flip-flop synchroniser for pin-level inputs
// Assumes: Inputs are asynchronous to clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sync_stage #(
   parameter int unsigned WIDTH = 1
)(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_reg <= '0;
         q_o      <= '0;
      end
      else
      begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule

/* File: verification/audio_far_side.sv */
// Purpose: Far-side model: loop and system clocks, lock level, slave serial clocks
// Assumes: Clock pins toggle on clk_i counts, slow enough to be sampled
// Notes:   Lock follows the bench request one cycle late, like a slow loop
`timescale 1ns/1ps
module audio_far_side #(
   parameter int unsigned EXT_HALF  = 6,
   parameter int unsigned LOOP_HALF = 2
)(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic lock_req_i,
   output logic      ext_system_clock_o,
   output logic      loop_clock_o,
   output logic      loop_lock_o,
   output logic      audio_bit_clock_o,
   output logic      audio_word_clock_o
);
   int unsigned ext_cnt;
   int unsigned loop_cnt;
   logic [7:0]  frame_cnt;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ext_cnt <= 0;
         loop_cnt <= 0;
         frame_cnt <= 8'h00;
         ext_system_clock_o <= 1'b0;
         loop_clock_o <= 1'b0;
         loop_lock_o <= 1'b0;
      end
      else
      begin
         ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
         loop_cnt <= (loop_cnt == LOOP_HALF - 1) ? 0 : loop_cnt + 1;
         if (ext_cnt == EXT_HALF - 1)
            ext_system_clock_o <= ~ext_system_clock_o;
         if (loop_cnt == LOOP_HALF - 1)
            loop_clock_o <= ~loop_clock_o;
         loop_lock_o <= lock_req_i;
         frame_cnt <= frame_cnt + 8'h01;
      end
   end
   // Slave mode: 32 bit clocks per word clock period
   assign audio_bit_clock_o = frame_cnt[2];
   assign audio_word_clock_o = frame_cnt[7];
endmodule

/* File: verification/rx_master_clock_select_tb.sv */
// Purpose: Self-checking bench for the master-clock and input-select block
// Assumes: Far side runs loop clock at 4 and system clock at 12 cycles a period
// Notes:   Clock rates are judged by edge counts, one edge of slack
`timescale 1ns/1ps
module rx_master_clock_select_tb;
   import mclk_sel_pkg::*;
   localparam int EH = 6;
   localparam int LH = 2;
   localparam int WIN = 480;
   logic                  clk_i = 1'b0;
   logic                  rst_i = 1'b1;
   logic                  chip_reset_n_i = 1'b0;
   logic [NUM_INPUTS-1:0] biphase_in_pos_i = '0;
   logic [ADDR_W-1:0]     addr_i = '0;
   logic [DATA_W-1:0]     wdata_i = '0;
   logic                  wr_i = 1'b0;
   logic                  rd_i = 1'b0;
   logic                  lock_req = 1'b0;
   logic                  rd_seen = 1'b0;
   logic [DATA_W-1:0]     rdata_o;
   logic                  low_power_o, rx_o, pass_o, mck_o, mck_oe_o;
   logic                  ext_clk, loop_clk, lock, far_bclk, far_wclk;
   logic                  bclk_o, bclk_oe_o, wclk_o, wclk_oe_o;
   logic [7:0]            exp_q[$];
   logic [7:0]            tol_q[$];
   string                 name_q[$];
   int                    n_fail = 0;
   int                    checked = 0;

   always #20 clk_i = ~clk_i;

   audio_far_side #(.EXT_HALF(EH), .LOOP_HALF(LH)) far (.clk_i(clk_i), .rst_i(rst_i),
      .lock_req_i(lock_req), .ext_system_clock_o(ext_clk), .loop_clock_o(loop_clk),
      .loop_lock_o(lock), .audio_bit_clock_o(far_bclk), .audio_word_clock_o(far_wclk));

   rx_master_clock_select DUT (.clk_i(clk_i), .rst_i(rst_i), .chip_reset_n_i(chip_reset_n_i),
      .biphase_in_pos_i(biphase_in_pos_i), .ext_system_clock_i(ext_clk), .loop_clock_i(loop_clk),
      .loop_lock_i(lock), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .low_power_o(low_power_o), .receiver_stream_o(rx_o),
      .passthrough_stream_o(pass_o), .recovered_master_clock_o(mck_o),
      .recovered_master_clock_oe_o(mck_oe_o),
      .audio_bit_clock_i(bclk_oe_o ? bclk_o : far_bclk), .audio_bit_clock_o(bclk_o),
      .audio_bit_clock_oe_o(bclk_oe_o), .audio_word_clock_i(wclk_oe_o ? wclk_o : far_wclk),
      .audio_word_clock_o(wclk_o), .audio_word_clock_oe_o(wclk_oe_o));

   task automatic test_done;
      if (n_fail == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g, input logic [15:0] t);
      checked++;
      if (((g + t) >= e && g <= (e + t)) !== 1'b1)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", w, e, g);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] t, input string w);
      exp_q.push_back(e);
      tol_q.push_back(t);
      name_q.push_back(w);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clk_i)
   begin
      if (rd_seen && exp_q.size() > 0)
         chk(name_q.pop_front(), {8'h00, exp_q.pop_front()}, {8'h00, rdata_o}, {8'h00, tol_q.pop_front()});
      rd_seen <= rd_i;
   end

   task automatic edges(input int n, output logic [15:0] m, output logic [15:0] b);
      logic pm;
      logic pb;
      m = '0;
      b = '0;
      pm = mck_o;
      pb = bclk_o;
      repeat (n)
      begin
         @(posedge clk_i);
         m = m + 16'(mck_o && !pm);
         b = b + 16'(bclk_o && !pb);
         pm = mck_o;
         pb = bclk_o;
      end
   endtask

   task automatic mode(input logic [7:0] c1, input logic lk, input logic [15:0] em);
      logic [15:0] m;
      logic [15:0] b;
      logic [15:0] nb;
      logic        pw;
      logic        pb;
      reg_wr(ADDR_CTRL1, c1);
      lock_req <= lk;
      repeat (60) @(posedge clk_i);
      edges(WIN, m, b);
      chk("mck_edges", em, m, 1);
      chk("bclk_oe", c1[C1_PORT_MSTR], bclk_oe_o, 0);
      chk("wclk_oe", c1[C1_PORT_MSTR], wclk_oe_o, 0);
      if (c1[C1_PORT_MSTR])
      begin
         chk("bclk_edges", em / 4, b, 1);
         // Half a word clock period holds 32 bit clocks: 64 bits per frame
         pw = wclk_o;
         while (wclk_o == pw)
            @(posedge clk_i);
         pw = wclk_o;
         nb = '0;
         pb = bclk_o;
         while (wclk_o == pw)
         begin
            @(posedge clk_i);
            nb = nb + 16'(bclk_o && !pb);
            pb = bclk_o;
         end
         chk("bclk_per_word", 16'h0020, nb, 1);
      end
   endtask

   initial
   begin
      #800000;
      n_fail++;
      test_done();
   end

   initial
   begin
      logic [7:0] d;
      logic [7:0] p;
      void'($urandom(32'hb9b8e5e1));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("low_power", 1, low_power_o, 0);
      chk("mck_oe", 0, mck_oe_o, 0);
      chip_reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("low_power", 0, low_power_o, 0);
      reg_rd(ADDR_CTRL1, CTRL1_RESET, 0, "ctrl1");
      reg_rd(ADDR_CTRL4, CTRL4_RESET, 0, "ctrl4");
      d = 8'($urandom);
      reg_wr(ADDR_CTRL1, d);
      reg_rd(ADDR_CTRL1, d & CTRL1_MASK, 0, "ctrl1");
      d = 8'($urandom);
      reg_wr(ADDR_CTRL4, d);
      reg_rd(ADDR_CTRL4, d & CTRL4_MASK, 0, "ctrl4");
      reg_rd(8'h20, 8'h00, 0, "unmapped");
      for (int s = 0; s < NUM_INPUTS; s++)
      begin
         reg_wr(ADDR_CTRL4, {2'b00, 3'(s), 3'(7 - s)});
         for (int k = 0; k < 3; k++)
         begin
            p = (k == 2) ? 8'($urandom) : ((8'h01 << s) ^ {8{k[0]}});
            biphase_in_pos_i <= p;
            repeat (6) @(posedge clk_i);
            chk("rx_stream", p[s], rx_o, 0);
            chk("pass_stream", p[7 - s], pass_o, 0);
         end
      end
      chk("mck_oe", 1, mck_oe_o, 0);
      reg_wr(ADDR_CTRL4, 8'h80);
      repeat (3) @(posedge clk_i);
      chk("mck_oe", 0, mck_oe_o, 0);
      reg_wr(ADDR_CTRL4, 8'h00);
      repeat (3) @(posedge clk_i);
      chk("mck_oe", 1, mck_oe_o, 0);
      mode(8'h00, 1'b1, WIN / (2 * LH));
      mode(8'h01, 1'b1, WIN / (4 * LH));
      mode(8'h04, 1'b1, WIN / (2 * LH));
      mode(8'h02, 1'b1, WIN / (2 * LH));
      mode(8'h02, 1'b0, WIN / (2 * EH));
      mode(8'h02, 1'b1, WIN / (2 * LH));
      reg_rd(ADDR_RATIO, 8'(64 * EH / LH), 2, "ratio");
      reg_wr(ADDR_CTRL1, 8'h07);
      chip_reset_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("low_power", 1, low_power_o, 0);
      reg_wr(ADDR_CTRL4, 8'h2A);
      chip_reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      reg_rd(ADDR_CTRL1, CTRL1_RESET, 0, "ctrl1");
      reg_rd(ADDR_CTRL4, CTRL4_RESET, 0, "ctrl4");
      repeat (4) @(posedge clk_i);
      test_done();
   end
endmodule
